//--- rtl/aac_pkg.sv
package aac_pkg;
    localparam int AAC_FIFO_DEPTH    = 32;
    localparam int AAC_FIFO_WIDTH    = 16;
    localparam int AAC_INSTR_COUNT   = 8;
    localparam int AAC_RES_HI        = 13;
    localparam int AAC_RES_LO        = 9;
    localparam int AAC_LIN_COUNT     = 13;
    localparam int AAC_CAL_AVG       = 8;
    localparam int AAC_ROM_DEPTH     = 16;
    localparam int AAC_CFG_DIAG_BIT  = 11;
    localparam int AAC_INS_LOOP_BIT  = 0;
    localparam int AAC_INS_PAUSE_BIT = 1;
    localparam int AAC_INS_POS_LSB   = 2;
    localparam int AAC_INS_NEG_LSB   = 5;
    localparam int AAC_INS_TIMER_BIT = 9;
    localparam int AAC_INS_RES8_BIT  = 10;
    localparam int AAC_INS_WDOG_BIT  = 11;
    localparam int AAC_INS_ACQ_LSB   = 12;
    localparam logic [15:0] AAC_CFG_RESET = 16'h0000;
    localparam logic [3:0]  AAC_ACQ_BASE  = 4'h2;
    typedef enum logic [1:0] {AAC_MODE_C12, AAC_MODE_C8, AAC_MODE_WDOG} aac_mode_t;
endpackage

//--- rtl/aac_fifo.sv
`timescale 1ns/1ps
module aac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic [WIDTH-1:0]           in_data,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [$clog2(DEPTH+1)-1:0] cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign count     = cnt_reg;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Arrival order kept by plain ring pointers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

//--- rtl/aac_core.sv
`timescale 1ns/1ps
module aac_core #(
    parameter int FIFO_DEPTH = aac_pkg::AAC_FIFO_DEPTH,
    parameter bit DIAG_ALLOWED = 1'b1
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 instr_we,
    input  wire logic [2:0]           instr_addr,
    input  wire logic [1:0]           instr_sect,
    input  wire logic [15:0]          instr_wdata,
    input  wire logic [15:0]          config_word,
    input  wire logic                 start,
    input  wire logic                 cal_offset,
    input  wire logic                 cal_full,
    input  wire logic [5:0]           int_count,
    input  wire logic [7:0]           int_mask,
    input  wire logic                 status_rd,
    output logic [7:0]                status,
    input  wire logic                 cmp_bit,
    output logic [12:0]               dac_code,
    output logic [2:0]                mux_pos,
    output logic [2:0]                mux_neg,
    output logic                      diag_sel,
    output logic                      sample,
    input  wire logic                 res_rd,
    output logic [15:0]               res_data,
    output logic                      res_valid,
    output logic [5:0]                res_count,
    output logic                      int_n,
    output logic                      xfer_req,
    output logic                      busy
);
    import aac_pkg::*;

    typedef enum logic [3:0] {S_IDLE, S_FETCH, S_TIMER, S_ACQ, S_CONV, S_CORR,
                              S_PUSH, S_CAL_ZERO, S_CAL_CAP, S_CAL_DONE} aac_state_t;

    logic [15:0] instr_mem [AAC_INSTR_COUNT];
    logic [15:0] lim1_mem  [AAC_INSTR_COUNT];
    logic [15:0] lim2_mem  [AAC_INSTR_COUNT];
    logic signed [15:0] lin_coef_reg [AAC_LIN_COUNT];
    logic signed [15:0] offset_coef_reg;

    aac_state_t  state_reg;
    logic [2:0]  pc_reg;
    logic [3:0]  bit_reg;
    logic [12:0] sar_reg;
    logic signed [19:0] acc_reg;
    logic [3:0]  rep_reg;
    logic [3:0]  cap_reg;
    logic [3:0]  rom_idx_reg;
    logic [15:0] timer_reg;
    logic [3:0]  acq_reg;
    logic        lim_sel_reg;
    logic        full_cal_reg;
    logic [7:0]  status_reg;
    logic        xfer_reg;
    logic [15:0] push_data_reg;
    logic        push_reg;

    // Calibration pattern table
    function automatic logic [7:0] cal_rom(input logic [3:0] idx);
        return {idx, ~idx};
    endfunction

    function automatic logic [3:0] res_bits(input logic [15:0] ins);
        return ins[AAC_INS_RES8_BIT] || ins[AAC_INS_WDOG_BIT] ?
               4'(AAC_RES_LO) : 4'(AAC_RES_HI);
    endfunction

    wire  [15:0] cur_ins   = instr_mem[pc_reg];
    wire  [3:0]  nbits     = res_bits(cur_ins);
    wire         is_wdog   = cur_ins[AAC_INS_WDOG_BIT];
    wire         is_c12    = !is_wdog && !cur_ins[AAC_INS_RES8_BIT];
    wire  [15:0] cur_lim   = lim_sel_reg ? lim2_mem[pc_reg] : lim1_mem[pc_reg];
    wire  [7:0]  rom_pat   = cal_rom(rom_idx_reg);
    wire         trial_one = cmp_bit;
    wire  [12:0] trial_bit = 13'h1 << bit_reg;
    // One calibration measurement: comparator low counts up, high counts down
    wire signed [19:0] meas_step = cmp_bit ? -20'sh1 : 20'sh1;

    // Sign-magnitude to two's complement, 12-bit left aligned
    wire  [11:0] mag12     = is_c12 ? sar_reg[11:0] : {sar_reg[7:0], 4'h0};
    // Sign is the first trial, so it sits lower at 8-bit resolution
    wire         sign_bit  = is_c12 ? sar_reg[12] : sar_reg[8];
    wire signed [15:0] raw_tc = sign_bit ? -$signed({4'h0, mag12})
                                            : $signed({4'h0, mag12});
    wire signed [19:0] lin_sum;
    wire signed [19:0] corrected = {{4{raw_tc[15]}}, raw_tc} - {{4{offset_coef_reg[15]}},
                                   offset_coef_reg} - (is_c12 ? lin_sum : 20'sh0);
    wire signed [8:0]  lim_val = {cur_lim[9], cur_lim[7:0]};
    wire signed [8:0]  smp_val = corrected[12:4];
    wire         above     = smp_val > lim_val;
    wire         lim_hit   = cur_lim[8] ? above : !above;

    // Background linearity sum over set result bits
    genvar g;
    wire signed [19:0] lin_part [AAC_LIN_COUNT];
    generate
        for (g = 0; g < AAC_LIN_COUNT; g++)
        begin : g_lin
            if (g == 0)
                assign lin_part[g] = sar_reg[g] ? {{4{lin_coef_reg[g][15]}}, lin_coef_reg[g]}
                                                : 20'sh0;
            else
                assign lin_part[g] = lin_part[g-1] + (sar_reg[g] ?
                                     {{4{lin_coef_reg[g][15]}}, lin_coef_reg[g]} : 20'sh0);
        end
    endgenerate
    assign lin_sum = lin_part[AAC_LIN_COUNT-1];

    logic [5:0] fifo_cnt;
    logic       fifo_in_ready;

    aac_fifo #(
        .WIDTH (AAC_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_data   (push_data_reg),
        .in_valid  (push_reg),
        .in_ready  (fifo_in_ready),
        .out_data  (res_data),
        .out_valid (res_valid),
        .out_ready (res_rd),
        .count     (fifo_cnt)
    );

    assign res_count = fifo_cnt;
    assign mux_pos   = cur_ins[AAC_INS_POS_LSB +: 3];
    assign mux_neg   = cur_ins[AAC_INS_NEG_LSB +: 3];
    assign diag_sel  = DIAG_ALLOWED && config_word[AAC_CFG_DIAG_BIT];
    assign sample    = (state_reg == S_ACQ);
    assign busy      = (state_reg != S_IDLE);
    assign status    = status_reg;
    assign int_n     = ~|(status_reg & int_mask);
    assign xfer_req  = xfer_reg;
    assign dac_code  = (state_reg == S_CONV) ? (sar_reg | trial_bit)
                     : (state_reg == S_CAL_CAP) ? {5'h0, rom_pat} : 13'h0;

    wire        cnt_hit  = (fifo_cnt == int_count) && (int_count != '0);
    wire        ff_full  = !fifo_in_ready;
    wire        push_now = (state_reg == S_PUSH) && !is_wdog && fifo_in_ready;
    wire        seq_last = cur_ins[AAC_INS_LOOP_BIT] || (pc_reg == 3'(AAC_INSTR_COUNT - 1));

    always_ff @(posedge clk)
    begin
        if (instr_we)
        begin
            if (instr_sect == 2'd0)
                instr_mem[instr_addr] <= instr_wdata;
            else if (instr_sect == 2'd1)
                lim1_mem[instr_addr] <= instr_wdata;
            else
                lim2_mem[instr_addr] <= instr_wdata;
        end
    end

    // Status bits: set wins over the read-clear
    wire [7:0] status_set = {3'h0, 1'b0, ff_full, cnt_hit,
                             (state_reg == S_CAL_DONE),
                             (state_reg == S_CORR) && is_wdog && lim_hit};

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            status_reg <= 8'h00;
        else
            status_reg <= (status_rd ? 8'h00 : status_reg) | status_set;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            xfer_reg <= 1'b0;
        else if (cnt_hit)
            xfer_reg <= 1'b1;
        else if (fifo_cnt == '0)
            xfer_reg <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg       <= S_IDLE;
            pc_reg          <= 3'h0;
            bit_reg         <= 4'h0;
            sar_reg         <= 13'h0;
            acc_reg         <= 20'sh0;
            rep_reg         <= 4'h0;
            cap_reg         <= 4'h0;
            rom_idx_reg     <= 4'h0;
            timer_reg       <= 16'h0;
            acq_reg         <= 4'h0;
            lim_sel_reg     <= 1'b0;
            full_cal_reg    <= 1'b0;
            offset_coef_reg <= 16'sh0;
            push_reg        <= 1'b0;
            push_data_reg   <= 16'h0;
            for (int i = 0; i < AAC_LIN_COUNT; i++)
                lin_coef_reg[i] <= 16'sh0;
        end
        else
        begin
            push_reg <= push_now;
            if (push_now)
                push_data_reg <= corrected[15:0];
            case (state_reg)
                S_IDLE:
                begin
                    if (cal_offset || cal_full)
                    begin
                        full_cal_reg <= cal_full;
                        rep_reg      <= 4'h0;
                        acc_reg      <= 20'sh0;
                        state_reg    <= S_CAL_ZERO;
                    end
                    else if (start)
                    begin
                        pc_reg    <= 3'h0;
                        state_reg <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    timer_reg   <= {cur_ins[15:12], 12'h0};
                    acq_reg     <= AAC_ACQ_BASE + cur_ins[AAC_INS_ACQ_LSB +: 4];
                    lim_sel_reg <= 1'b0;
                    state_reg   <= cur_ins[AAC_INS_TIMER_BIT] ? S_TIMER : S_ACQ;
                end
                S_TIMER:
                begin
                    timer_reg <= timer_reg - 16'h1;
                    if (timer_reg == 16'h0)
                        state_reg <= S_ACQ;
                end
                S_ACQ:
                begin
                    acq_reg <= acq_reg - 4'h1;
                    if (acq_reg == 4'h0)
                    begin
                        sar_reg   <= 13'h0;
                        bit_reg   <= nbits - 4'h1;
                        state_reg <= S_CONV;
                    end
                end
                // One trial per bit: 9 cycles versus 13 cycles
                S_CONV:
                begin
                    if (trial_one)
                        sar_reg <= sar_reg | trial_bit;
                    if (bit_reg == 4'h0)
                        state_reg <= S_CORR;
                    else
                        bit_reg <= bit_reg - 4'h1;
                end
                S_CORR:
                begin
                    if (is_wdog && !lim_sel_reg)
                    begin
                        lim_sel_reg <= 1'b1;
                        state_reg   <= S_CORR;
                    end
                    else
                        state_reg <= S_PUSH;
                end
                // Stall on a full buffer rather than drop a result
                S_PUSH:
                begin
                    if (is_wdog || fifo_in_ready)
                    begin
                        if (!start)
                            state_reg <= S_IDLE;
                        else
                        begin
                            pc_reg    <= seq_last ? 3'h0 : pc_reg + 3'h1;
                            state_reg <= S_FETCH;
                        end
                    end
                end
                S_CAL_ZERO:
                begin
                    acc_reg <= acc_reg + meas_step;
                    rep_reg <= rep_reg + 4'h1;
                    if (!full_cal_reg)
                    begin
                        offset_coef_reg <= 16'(meas_step);
                        state_reg       <= S_CAL_DONE;
                    end
                    else if (rep_reg == 4'(AAC_CAL_AVG - 1))
                    begin
                        offset_coef_reg <= 16'((acc_reg + meas_step) >>> 3);
                        rep_reg         <= 4'h0;
                        cap_reg         <= 4'h0;
                        rom_idx_reg     <= 4'h0;
                        acc_reg         <= 20'sh0;
                        state_reg       <= S_CAL_CAP;
                    end
                end
                S_CAL_CAP:
                begin
                    rom_idx_reg <= rom_idx_reg + 4'h1;
                    acc_reg     <= acc_reg + meas_step;
                    rep_reg     <= rep_reg + 4'h1;
                    if (rep_reg == 4'(AAC_CAL_AVG - 1))
                    begin
                        lin_coef_reg[cap_reg] <= 16'((acc_reg + meas_step) >>> 3);
                        rep_reg <= 4'h0;
                        acc_reg <= 20'sh0;
                        if (cap_reg == 4'(AAC_LIN_COUNT - 1))
                            state_reg <= S_CAL_DONE;
                        else
                            cap_reg <= cap_reg + 4'h1;
                    end
                end
                S_CAL_DONE:
                    state_reg <= S_IDLE;
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

//--- testbench/aac_core_props.sv
`timescale 1ns/1ps
module aac_core_props #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [15:0] config_word,
    input wire logic [5:0]  int_count,
    input wire logic [7:0]  int_mask,
    input wire logic        status_rd,
    input wire logic [7:0]  status,
    input wire logic        diag_sel,
    input wire logic        res_rd,
    input wire logic [15:0] res_data,
    input wire logic        res_valid,
    input wire logic [5:0]  res_count,
    input wire logic        int_n,
    input wire logic        xfer_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_count_bound: assert property (res_count <= FIFO_DEPTH)
        else $error("result count above depth");
    a_full_flag: assert property (res_count == FIFO_DEPTH |-> ##[0:1] status[3])
        else $error("full flag missing");
    a_count_flag: assert property ((int_count != 0 && res_count == int_count) |-> ##[0:1] status[2])
        else $error("count flag missing");
    a_xfer_raise: assert property ((int_count != 0 && res_count == int_count) |-> ##[0:1] xfer_req)
        else $error("transfer request missing");
    a_xfer_drop: assert property (res_count == 0 |-> ##[0:1] !xfer_req)
        else $error("transfer request held when empty");
    a_int_assert: assert property ((|(status & int_mask)) |-> ##[0:1] !int_n)
        else $error("interrupt not driven low");
    // Clear may land one cycle late, so skip the cycle after a read
    a_status_sticky: assert property ((!status_rd && !$past(status_rd)) |=> ((status & $past(status)) == $past(status)))
        else $error("status bit lost without read");
    a_data_stands: assert property ((res_valid && !res_rd) |=> (res_valid && $stable(res_data)))
        else $error("result changed before pop");
    a_sign_ext: assert property (res_valid |-> res_data[15:12] == {4{res_data[12]}})
        else $error("result not sign extended");
    a_diag_follow: assert property (config_word[11] |-> ##[0:1] diag_sel)
        else $error("diagnostic select missing");
endmodule

//--- testbench/aac_host_model.sv
`timescale 1ns/1ps
module aac_host_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        enable,
    input  wire logic        slow,
    input  wire logic        res_valid,
    output logic             res_rd,
    output logic [15:0]      pop_cnt
);
    logic [1:0] phase_reg = 2'h0;
    initial res_rd = 1'b0;
    // Reads whenever it likes; slow mode stalls three cycles of four
    always @(negedge clk)
    begin
        phase_reg <= phase_reg + 2'h1;
        res_rd    <= enable && (!slow || phase_reg == 2'h3);
    end
    always @(posedge clk)
    begin
        if (!reset_n)
            pop_cnt <= 16'h0000;
        else if (res_rd && res_valid)
            pop_cnt <= pop_cnt + 16'h0001;
    end
endmodule

//--- testbench/adc_acquisition_control_tb_top.sv
`timescale 1ns/1ps
module adc_acquisition_control_tb_top;
    import aac_pkg::*;
    localparam int DEPTH = AAC_FIFO_DEPTH;
    logic        clk = 1'b0, reset_n = 1'b0, instr_we = 1'b0, start = 1'b0;
    logic        cal_offset = 1'b0, cal_full = 1'b0, status_rd = 1'b0, cmp_bit = 1'b0;
    logic        host_en = 1'b0, host_slow = 1'b0, sample_d = 1'b0, model_on = 1'b0;
    logic [2:0]  instr_addr = 3'h0, mux_pos, mux_neg;
    logic [1:0]  instr_sect = 2'h0;
    logic [15:0] instr_wdata = 16'h0000, config_word = AAC_CFG_RESET, res_data;
    logic [5:0]  int_count = 6'h00, res_count;
    logic [7:0]  int_mask = 8'h00, status;
    logic [12:0] dac_code;
    logic        diag_sel, sample, res_rd, res_valid, int_n, xfer_req, busy;
    logic [15:0] pop_cnt, pop0;
    logic [12:0] trial_sh = 13'h0;
    int          error_cnt = 0, checks = 0, seed = 5507, n_trial = 0;
    logic [5:0]  exp_mux[$];
    logic [15:0] exp_res[$];
    always #25 clk = ~clk;
    always @(negedge clk) cmp_bit <= $random(seed);
    aac_core u_dut (.clk(clk), .reset_n(reset_n), .instr_we(instr_we), .instr_addr(instr_addr),
        .instr_sect(instr_sect), .instr_wdata(instr_wdata), .config_word(config_word),
        .start(start), .cal_offset(cal_offset), .cal_full(cal_full), .int_count(int_count),
        .int_mask(int_mask), .status_rd(status_rd), .status(status), .cmp_bit(cmp_bit),
        .dac_code(dac_code), .mux_pos(mux_pos), .mux_neg(mux_neg), .diag_sel(diag_sel),
        .sample(sample), .res_rd(res_rd), .res_data(res_data), .res_valid(res_valid),
        .res_count(res_count), .int_n(int_n), .xfer_req(xfer_req), .busy(busy));
    aac_host_model u_host (.clk(clk), .reset_n(reset_n), .enable(host_en), .slow(host_slow),
        .res_valid(res_valid), .res_rd(res_rd), .pop_cnt(pop_cnt));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Sign-magnitude trial bits, first trial is the sign, to two's complement
    function automatic logic [15:0] tc_of(input logic [12:0] sh, input int n);
        logic [15:0] mag;
        mag = (n == 13) ? {4'h0, sh[11:0]} : {4'h0, sh[7:0], 4'h0};
        return ((n == 13) ? sh[12] : sh[8]) ? 16'h0 - mag : mag;
    endfunction
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic write_instr(input int addr, input int sect, input logic [15:0] data);
        instr_we    = 1'b1;
        instr_addr  = 3'(addr);
        instr_sect  = 2'(sect);
        instr_wdata = data;
        cycles(1);
        instr_we    = 1'b0;
        cycles(1);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 30000 && busy !== 1'b0; i++) cycles(1);
    endtask
    task automatic read_status();
        status_rd = 1'b1;
        cycles(1);
        status_rd = 1'b0;
        cycles(2);
    endtask
    // Scoreboard side: oldest note against what just came out
    always @(posedge clk)
    begin
        sample_d <= sample;
        if (sample && !sample_d && exp_mux.size() > 0)
            check("channel pair", {mux_neg, mux_pos}, exp_mux.pop_front());
        // Trial cycles are the ones with a code on the DAC
        if (dac_code != 13'h0)
        begin
            trial_sh <= {trial_sh[11:0], cmp_bit};
            n_trial  <= n_trial + 1;
        end
        else if (n_trial > 0)
        begin
            n_trial <= 0;
            if (model_on)
            begin
                check("trial count", n_trial, mux_pos[0] ? 9 : 13);
                exp_res.push_back(tc_of(trial_sh, n_trial));
            end
        end
        if (res_valid && res_rd)
        begin
            if (exp_res.size() == 0)
                check("result note", 1'b1, 1'b0);
            else
                check("result order", res_data, exp_res.pop_front());
            check("sign extension", res_data[15:12], {4{res_data[12]}});
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial
    begin
        cycles(8);
        check("reset int_n", int_n, 1'b1);
        check("reset xfer_req", {xfer_req, res_valid, busy, status}, 11'h000);
        reset_n = 1'b1;
        // Odd steps at low resolution; last step single ended with loop
        for (int i = 0; i < 8; i++)
            write_instr(i, 0, 16'(i) << AAC_INS_POS_LSB | 16'(7 - i) << AAC_INS_NEG_LSB
                | 16'(i % 2) << AAC_INS_RES8_BIT | 16'(i == 7));
        for (int j = 0; j < 64; j++) exp_mux.push_back({3'(7 - j % 8), 3'(j % 8)});
        int_count = 6'h05;
        int_mask  = 8'h0c;
        model_on  = 1'b1;
        start     = 1'b1;
        for (int i = 0; i < 4000 && res_count != DEPTH; i++) cycles(1);
        cycles(2);
        check("full count", res_count, DEPTH);
        check("transfer request", xfer_req, 1'b1);
        check("full and count flags", status[3:2], 2'b11);
        check("interrupt low", int_n, 1'b0);
        // Next step must wait at the full buffer, not overwrite it
        cycles(40);
        check("stall on full", {busy, res_count}, {1'b1, 6'(DEPTH)});
        start     = 1'b0;
        host_en   = 1'b1;
        host_slow = 1'b1;
        wait_idle();
        for (int i = 0; i < 2000 && res_count != 0; i++) cycles(1);
        cycles(2);
        // The stalled step lands once a word is read
        check("pops from full", pop_cnt, DEPTH + 1);
        check("request dropped", xfer_req, 1'b0);
        read_status();
        check("status cleared", status, 8'h00);
        check("interrupt released", int_n, 1'b1);
        exp_mux.delete();
        pop0      = pop_cnt;
        host_slow = 1'b0;
        start     = 1'b1;
        cycles(400);
        start = 1'b0;
        wait_idle();
        cycles(3);
        for (int i = 0; i < 200 && res_count != 0; i++) cycles(1);
        check("reads during run", (pop_cnt - pop0) > 16'd8, 1'b1);
        check("results all read", exp_res.size(), 0);
        check("buffer drained", {res_valid, res_count}, 7'h00);
        model_on = 1'b0;
        host_en = 1'b0;
        config_word[AAC_CFG_DIAG_BIT] = 1'b1;
        cycles(2);
        check("diag on", diag_sel, 1'b1);
        config_word[AAC_CFG_DIAG_BIT] = 1'b0;
        cycles(2);
        check("diag off", diag_sel, 1'b0);
        read_status();
        int_mask = 8'h02;
        for (int k = 0; k < 2; k++)
        begin
            {cal_full, cal_offset} = k ? 2'b10 : 2'b01;
            cycles(1);
            {cal_full, cal_offset} = 2'b00;
            cycles(3);
            wait_idle();
            check("cal done", status[1], 1'b1);
            check("cal interrupt", int_n, 1'b0);
            read_status();
            check("cal done cleared", status[1], 1'b0);
        end
        // Every step compares, so no step may leave a result behind
        for (int i = 0; i < 8; i++)
        begin
            write_instr(i, 0, 16'h0001 | 16'h0001 << AAC_INS_WDOG_BIT);
            write_instr(i, 1, 16'($random(seed)) & 16'h03ff);
            write_instr(i, 2, 16'($random(seed)) & 16'h03ff);
        end
        int_mask = 8'h01;
        start    = 1'b1;
        cycles(300);
        start = 1'b0;
        wait_idle();
        check("window pushes none", res_count, 6'h00);
        give_verdict();
    end
endmodule
bind aac_core aac_core_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk(clk), .reset_n(reset_n),
    .config_word(config_word), .int_count(int_count), .int_mask(int_mask),
    .status_rd(status_rd), .status(status), .diag_sel(diag_sel), .res_rd(res_rd),
    .res_data(res_data), .res_valid(res_valid), .res_count(res_count), .int_n(int_n),
    .xfer_req(xfer_req));
